// [hw/phy_strap_mode_control.sv]
// strap and mode control of a 10/100 transceiver with an APB register port
// assumes tx_active, rx_active, collision_det and tx_done come from logic on
// pclk; straps and control pins are asynchronous board levels
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "phy_strap_params.svh"

module phy_strap_mode_control #(
  parameter int ADDR_W = 12
) (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // board straps and control pins
  input wire logic low_power_request,
  input wire logic float_pin,
  input wire logic float_default_strap,
  input wire logic autoneg_allow_strap,
  input wire logic [2:0] ability_select_strap,
  input wire logic repeater_strap,
  // activity from the data path
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic collision_det,
  input wire logic tx_done,
  // mode outputs
  output logic low_power,
  output logic mii_oe,
  output logic crs,
  output logic col,
  output logic autoneg_enable,
  output logic speed_100,
  output logic full_duplex,
  output logic repeater_mode
);

  initial begin
    if (ADDR_W < 8) begin
      $error("phy_strap_mode_control: ADDR_W must be at least 8");
    end
  end

  // both reset sources act on every flop
  logic chip_rst_n;
  assign chip_rst_n = presetn & power_on_reset_n;

  // synchronised pins
  logic [7:0] pins_sync;
  logic lp_pin_s, float_pin_s, float_def_s, an_allow_s, repeater_strap_s;
  logic [2:0] ability_s;

  strap_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk(pclk),
    .rst_n(chip_rst_n),
    .pin_in({low_power_request, float_pin, float_default_strap, autoneg_allow_strap,
              ability_select_strap, repeater_strap}),
    .pin_sync(pins_sync)
  );

  assign lp_pin_s = pins_sync[7];
  assign float_pin_s = pins_sync[6];
  assign float_def_s = pins_sync[5];
  assign an_allow_s = pins_sync[4];
  assign ability_s = pins_sync[3:1];
  assign repeater_strap_s = pins_sync[0];

  // control state
  phy_strap_pkg::rst_state_t rs_r;
  logic [1:0] settle_r;
  logic an_en_r, lp_bit_r, float_bit_r, speed_r, duplex_r, repeater_strap_bit_r;
  logic [2:0] ability_r;
  logic [3:0] sqe_cnt_r;

  // repeater mode from strap or vendor bit
  logic repeater_strap_act;
  assign repeater_strap_act = repeater_strap_s | repeater_strap_bit_r;

  // ability decode of the latched code, and of the live strap for loading
  phy_strap_pkg::ability_t stat_ab, adv_ab;
  logic ld_speed, ld_full;

  ability_decode u_dec (
    .code(ability_r),
    .repeater(repeater_strap_act),
    .stat_ab(stat_ab),
    .adv_ab(adv_ab),
    .def_speed100(),
    .def_full()
  );

  ability_decode u_dec_ld (
    .code(ability_s),
    .repeater(repeater_strap_s),
    .stat_ab(),
    .adv_ab(),
    .def_speed100(ld_speed),
    .def_full(ld_full)
  );

  // apb decode; the access phase takes one wait state
  logic acc, wr_fire, rd_fire, mapped, aligned;
  logic [4:0] idx;
  assign acc = psel & penable;
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:7] == '0);
  assign idx = paddr[6:2];
  assign mapped = aligned && ((idx == `IDX_CTRL) || (idx == `IDX_STAT) ||
                  (idx == `IDX_ADV) || (idx == `IDX_VEND) || (idx == `IDX_PINS));
  assign wr_fire = acc & pready & pwrite & mapped;
  assign rd_fire = acc & ~pready & ~pwrite;

  // soft reset request from a control write
  logic soft_req;
  assign soft_req = wr_fire && (idx == `IDX_CTRL) && pwdata[`CTRL_SOFT_RESET];

  // reset sequencer: settle synchronisers, load straps, then run
  always_ff @(posedge pclk or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      rs_r <= phy_strap_pkg::RS_SETTLE;
      settle_r <= `STRAP_SETTLE_CYCLES;
    end else begin
      case (rs_r)
        phy_strap_pkg::RS_SETTLE: begin
          if (settle_r == 2'h1) begin
            rs_r <= phy_strap_pkg::RS_LOAD;
          end
          settle_r <= settle_r - 2'h1;
        end
        phy_strap_pkg::RS_LOAD: begin
          rs_r <= phy_strap_pkg::RS_RUN;
        end
        phy_strap_pkg::RS_RUN: begin
          if (soft_req) begin
            rs_r <= phy_strap_pkg::RS_LOAD;
          end
        end
        default: begin
          rs_r <= phy_strap_pkg::RS_SETTLE;
        end
      endcase
    end
  end

  // control register bits, defaults loaded from straps on every reset, low power from its reset constant
  always_ff @(posedge pclk or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      an_en_r <= 1'b0;
      lp_bit_r <= `RST_LOW_POWER;
      float_bit_r <= 1'b0;
      speed_r <= 1'b0;
      duplex_r <= 1'b0;
      repeater_strap_bit_r <= `RST_REPEATER;
      ability_r <= 3'h0;
    end else if (rs_r == phy_strap_pkg::RS_LOAD) begin
      an_en_r <= an_allow_s;
      lp_bit_r <= `RST_LOW_POWER;
      float_bit_r <= float_def_s;
      speed_r <= ld_speed;
      duplex_r <= ld_full & ~repeater_strap_s;
      repeater_strap_bit_r <= `RST_REPEATER;
      ability_r <= ability_s;
    end else if (wr_fire && !soft_req && rs_r == phy_strap_pkg::RS_RUN) begin
      if (idx == `IDX_CTRL) begin
        an_en_r <= pwdata[`CTRL_AN_EN] & an_allow_s;
        lp_bit_r <= pwdata[`CTRL_LOW_POWER];
        float_bit_r <= pwdata[`CTRL_FLOAT];
        speed_r <= pwdata[`CTRL_SPEED];
        duplex_r <= pwdata[`CTRL_DUPLEX] & ~repeater_strap_act;
      end
      if (idx == `IDX_VEND) begin
        repeater_strap_bit_r <= pwdata[`VEND_REPEATER];
      end
    end else begin
      if (repeater_strap_act) begin
        duplex_r <= 1'b0;
      end
      if (!an_allow_s) begin
        an_en_r <= 1'b0;
      end
    end
  end

  // read data mux
  logic [15:0] rd_val;
  always_comb begin
    rd_val = 16'h0000;
    case (idx)
      `IDX_CTRL: begin
        rd_val[`CTRL_SOFT_RESET] = (rs_r != phy_strap_pkg::RS_RUN);
        rd_val[`CTRL_SPEED] = speed_r;
        rd_val[`CTRL_AN_EN] = an_en_r;
        rd_val[`CTRL_LOW_POWER] = lp_bit_r;
        rd_val[`CTRL_FLOAT] = float_bit_r;
        rd_val[`CTRL_DUPLEX] = duplex_r;
      end
      `IDX_STAT: begin
        rd_val[`STAT_AB_LSB +: 4] = stat_ab;
        rd_val[`STAT_AN_ABILITY] = an_allow_s;
        rd_val[`STAT_EXT_CAP] = 1'b1;
      end
      `IDX_ADV: begin
        rd_val = `ADV_SELECTOR;
        rd_val[`ADV_AB_LSB +: 4] = adv_ab;
      end
      `IDX_VEND: begin
        rd_val[`VEND_REPEATER] = repeater_strap_bit_r;
      end
      `IDX_PINS: begin
        rd_val = {6'h00, lp_pin_s | lp_bit_r, float_pin_s | float_bit_r, pins_sync};
      end
      default: begin
        rd_val = 16'h0000;
      end
    endcase
  end

  // apb answer: ready one cycle into the access phase, error if unmapped
  always_ff @(posedge pclk or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (rd_fire) begin
        prdata <= mapped ? {16'h0000, rd_val} : 32'h00000000;
      end
    end
  end

  // collision test window after each 10 Mb/s transmission outside repeater mode
  always_ff @(posedge pclk or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      sqe_cnt_r <= 4'h0;
    end else if (tx_done && !speed_r && !repeater_strap_act) begin
      sqe_cnt_r <= `SQE_CYCLES;
    end else if (sqe_cnt_r != 4'h0) begin
      sqe_cnt_r <= sqe_cnt_r - 4'h1;
    end
  end

  // mode and MII outputs, all registered
  always_ff @(posedge pclk or negedge chip_rst_n) begin
    if (!chip_rst_n) begin
      low_power <= 1'b0;
      mii_oe <= 1'b0;
      crs <= 1'b0;
      col <= 1'b0;
      autoneg_enable <= 1'b0;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
      repeater_mode <= 1'b0;
    end else begin
      low_power <= lp_pin_s | lp_bit_r;
      mii_oe <= ~(float_pin_s | float_bit_r) && (rs_r == phy_strap_pkg::RS_RUN);
      if (lp_pin_s | lp_bit_r) begin
        crs <= 1'b0;
        col <= 1'b0;
      end else begin
        crs <= repeater_strap_act ? rx_active : (tx_active | rx_active);
        col <= collision_det | ((sqe_cnt_r != 4'h0) & ~repeater_strap_act);
      end
      autoneg_enable <= an_en_r & an_allow_s;
      speed_100 <= speed_r;
      full_duplex <= duplex_r & ~repeater_strap_act;
      repeater_mode <= repeater_strap_act;
    end
  end

endmodule

// [hw/phy_strap_params.svh]
// constants of the strap and mode control block: register indices, field
// positions, reset values and timing counts
// assumes inclusion by bare name from any file that needs them
`ifndef PHY_STRAP_PARAMS_SVH
`define PHY_STRAP_PARAMS_SVH

// register indices, byte address is four times the index
`define IDX_CTRL 5'h00
`define IDX_STAT 5'h01
`define IDX_ADV 5'h04
`define IDX_VEND 5'h10
`define IDX_PINS 5'h18

// control register fields
`define CTRL_SOFT_RESET 15
`define CTRL_SPEED 13
`define CTRL_AN_EN 12
`define CTRL_LOW_POWER 11
`define CTRL_FLOAT 10
`define CTRL_DUPLEX 8

// status register fields
`define STAT_AB_LSB 11
`define STAT_AN_ABILITY 3
`define STAT_EXT_CAP 0

// advertisement register fields
`define ADV_AB_LSB 5
`define ADV_SELECTOR 16'h0001

// vendor register fields
`define VEND_REPEATER 15

// reset values of writable bits
`define RST_LOW_POWER 1'b0
`define RST_REPEATER 1'b0

// timing counts in pclk cycles
`define STRAP_SETTLE_CYCLES 2'h3
`define SQE_CYCLES 4'h4

`endif

// [hw/phy_strap_pkg.sv]
// types shared by the strap and mode control block
// assumes the constants header is included where numbers are needed
package phy_strap_pkg;

  // reset sequencer: wait for synchronised straps, load defaults, run
  typedef enum logic [1:0] {
    RS_SETTLE,
    RS_LOAD,
    RS_RUN
  } rst_state_t;

  // four technology abilities: 100 full, 100 half, 10 full, 10 half
  typedef logic [3:0] ability_t;

endpackage

// [hw/strap_sync.sv]
// two-flop synchroniser for a group of board pins
// assumes pins are static or slow compared to clk
`timescale 1ns/1ps

module strap_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and synchronised copies
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  initial begin
    if (WIDTH < 1) begin
      $error("strap_sync: WIDTH must be at least 1");
    end
  end

  // one pair of flops per pin; the first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic meta_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          pin_sync[i] <= 1'b0;
        end else begin
          meta_r <= pin_in[i];
          pin_sync[i] <= meta_r;
        end
      end
    end
  endgenerate

endmodule

// [hw/ability_decode.sv]
// decodes the 3-bit technology ability code into ability sets and defaults
// assumes callers register the results; purely combinational
`timescale 1ns/1ps

module ability_decode (
  // code and mode
  input wire logic [2:0] code,
  input wire logic repeater,
  // decoded abilities
  output phy_strap_pkg::ability_t stat_ab,
  output phy_strap_pkg::ability_t adv_ab,
  output logic def_speed100,
  output logic def_full
);

  phy_strap_pkg::ability_t raw;

  // ability order: [3] 100 full, [2] 100 half, [1] 10 full, [0] 10 half
  always_comb begin
    case (code)
      3'h0: raw = 4'h0;
      3'h1: raw = 4'h1;
      3'h2: raw = 4'h4;
      3'h3: raw = 4'h5;
      3'h4: raw = 4'h0;
      3'h5: raw = 4'h3;
      3'h6: raw = 4'hc;
      default: raw = 4'hf;
    endcase
  end

  // code 000 advertises nothing yet parallel detect may pick either speed
  always_comb begin
    stat_ab = raw;
    adv_ab = raw;
    if (code == 3'h0) begin
      stat_ab = 4'h5;
      adv_ab = 4'h0;
    end
    if (repeater) begin
      stat_ab = stat_ab & 4'h5;
      adv_ab = adv_ab & 4'h5;
    end
    def_speed100 = stat_ab[3] | stat_ab[2];
    def_full = stat_ab[3] | stat_ab[1];
  end

endmodule

// [tb/phy_strap_chk_sva.sv]
// assertions on the ports of the strap and mode control block
// assumes binding to phy_strap_mode_control, one pclk domain
`timescale 1ns/1ps
module phy_strap_chk (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic power_on_reset_n,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // pins and activity
  input wire logic float_pin,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic collision_det,
  input wire logic tx_done,
  // mode outputs
  input wire logic low_power,
  input wire logic mii_oe,
  input wire logic crs,
  input wire logic col,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic repeater_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !power_on_reset_n);

  // register access answers after one wait state in every mode
  property p_apb_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
  // low power silences carrier and collision
  property p_lp_quiet; low_power && $past(low_power) |-> !crs && !col; endproperty
  a_lp_quiet: assert property (p_lp_quiet) else $error("activity in low power");
  // float pin held four cycles releases the mii outputs
  property p_float; float_pin [*4] |-> !mii_oe; endproperty
  a_float: assert property (p_float) else $error("mii still driven");
  // receive activity gives carrier one cycle later
  property p_crs_rx; (!low_power && rx_active) ##1 !low_power |-> crs; endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("carrier missing on receive");
  // transmit activity gives carrier outside repeater mode
  property p_crs_tx;
    (!repeater_mode && !low_power && tx_active) ##1 !low_power |-> crs;
  endproperty
  a_crs_tx: assert property (p_crs_tx) else $error("carrier missing on transmit");
  // repeater carrier ignores transmit
  property p_crs_rpt; (repeater_mode && !rx_active) ##1 !low_power |-> !crs; endproperty
  a_crs_rpt: assert property (p_crs_rpt) else $error("carrier from transmit");
  // repeater forbids full duplex
  property p_rpt_dup; repeater_mode && $past(repeater_mode) |-> !full_duplex; endproperty
  a_rpt_dup: assert property (p_rpt_dup) else $error("full duplex in repeater");
  // collision test window after a 10 Mb/s transmit: counter loads, then col shows
  property p_sqe;
    tx_done && !speed_100 && !repeater_mode && !low_power |=> ##1 col [*4];
  endproperty
  a_sqe: assert property (p_sqe) else $error("collision test window wrong");
  // no collision test in repeater mode
  property p_no_sqe; tx_done && repeater_mode && !collision_det |=> !col; endproperty
  a_no_sqe: assert property (p_no_sqe) else $error("collision test in repeater");
endmodule

bind phy_strap_mode_control phy_strap_chk phy_strap_chk_i (.pclk, .presetn,
  .power_on_reset_n, .psel, .penable, .pready, .float_pin, .tx_active, .rx_active,
  .collision_det, .tx_done, .low_power, .mii_oe, .crs, .col, .speed_100,
  .full_duplex, .repeater_mode);

// [tb/board_straps.sv]
// board model: strap resistors set while the device is held in reset
// assumes straps change only while the device is held in reset
`timescale 1ns/1ps
module board_straps (
  // wanted setting: float default, autoneg, ability code, repeater
  input wire logic [5:0] setting,
  // strap pins
  output logic float_default_strap,
  output logic autoneg_allow_strap,
  output logic [2:0] ability_select_strap,
  output logic repeater_strap
);
  // straps are plain static levels
  assign {float_default_strap, autoneg_allow_strap, ability_select_strap,
          repeater_strap} = setting;
endmodule

// [tb/tb.sv]
// self-checking bench of the strap and mode control block
// assumes the checker is bound and board_straps drives the straps
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, power_on_reset_n = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic low_power_request = 1'b0, float_pin = 1'b0, tx_active = 1'b0, rx_active = 1'b0;
  logic collision_det = 1'b0, tx_done = 1'b0;
  logic [5:0] setting = 6'h00;
  logic float_default_strap, autoneg_allow_strap, repeater_strap;
  logic [2:0] ability_select_strap;
  logic low_power, mii_oe, crs, col, autoneg_enable, speed_100, full_duplex, repeater_mode;
  logic [3:0] ab;
  int fails = 0;
  int comparisons = 0;
  // ability sets per code, one nibble each: 100f 100h 10f 10h
  localparam logic [31:0] stat_tab = 32'hfc305415;
  localparam logic [31:0] adv_tab = 32'hfc305410;

  // clock of 25 ns
  always #12.5 pclk = ~pclk;

  board_straps board_straps_i (.setting, .float_default_strap, .autoneg_allow_strap,
    .ability_select_strap, .repeater_strap);
  phy_strap_mode_control phy_strap_mode_control_i (.pclk, .presetn, .power_on_reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .low_power_request, .float_pin, .float_default_strap, .autoneg_allow_strap,
    .ability_select_strap, .repeater_strap, .tx_active, .rx_active, .collision_det,
    .tx_done, .low_power, .mii_oe, .crs, .col, .autoneg_enable, .speed_100,
    .full_duplex, .repeater_mode);

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one apb transfer, read data and error left in rd and er
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look between edges, where the registered answer has settled
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    // the next rising edge samples pready high and ends the transfer
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fails++;
      final_report;
    end
  endtask

  // reset by the pin or by power-on, straps set meanwhile
  task automatic rst(input logic [5:0] s, input logic por);
    setting <= s;
    if (por) power_on_reset_n <= 1'b0;
    else presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    power_on_reset_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  // main sequence
  initial begin
    for (int c = 0; c < 8; c++) begin
      rst({c[0], c[1], c[2:0], 1'b0}, c[1]);
      ab = stat_tab[4*c +: 4];
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {17'h0, ab, 7'h0, c[1], 3'h1});
      chk(speed_100, ab[3] | ab[2]);
      chk(full_duplex, ab[3] | ab[1]);
      ab = adv_tab[4*c +: 4];
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, {23'h0, ab, 5'h01});
      apb(1'b0, 12'h060, 32'h0);
      chk(rd, {23'h0, c[0], 2'h0, setting});
      apb(1'b0, 12'h000, 32'h0);
      chk(rd & 32'h9c00, {19'h0, c[1], 1'b0, c[0], 10'h0});
      chk(mii_oe, !c[0]);
      chk(autoneg_enable, c[1]);
    end
    rst(6'h1e, 1'b0);
    apb(1'b1, 12'h000, 32'h0);
    for (int r = 1; r >= 0; r--) begin
      apb(1'b1, 12'h040, {16'h0, r[0], 15'h0});
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, r[0] ? 32'h2809 : 32'h7809);
      chk(full_duplex, 1'b0);
      tx_active <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(crs, !r[0]);
      tx_active <= 1'b0;
      rx_active <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(crs, 1'b1);
      rx_active <= 1'b0;
      tx_done <= 1'b1;
      @(posedge pclk);
      tx_done <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(col, !r[0]);
      chk(repeater_mode, r[0]);
    end
    apb(1'b1, 12'h000, 32'h0800);
    repeat (3) @(posedge pclk);
    chk(low_power, 1'b1);
    apb(1'b1, 12'h040, 32'h8000);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0800);
    apb(1'b1, 12'h000, 32'h8000);
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd & 32'h9c00, 32'h1000);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    chk(low_power, 1'b0);
    low_power_request <= 1'b1;
    float_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(low_power, 1'b1);
    chk(mii_oe, 1'b0);
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 32'h3de);
    low_power_request <= 1'b0;
    float_pin <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 12'h002, 32'hffff);
    chk(er, 1'b1);
    final_report;
  end
endmodule
